// file: design/ispl_pkg.sv
// Purpose: Shared constants for the interleaved serial port and LAN clock ends.
// Assumes: One system clock at 125 MHz; line clocks and reference clock are sampled inputs.
// Notes:   Serial bits travel most significant bit first.
//
// What this block does
// R01 - Launch transmit bit on transmit clock rise.
// R02 - Gapped transmit clock: skipped periods send nothing.
// R03 - Transmit pulse marks channel 1; aligns bytes.
// R04 - Receive pulse marks channel 1; aligns bytes.
// R05 - Capture receive bit on receive clock rise.
// R06 - Gapped receive clock: missing periods take nothing.
// R07 - T1 frame: framing bit, then 24 channels.
// R08 - RMII signals synchronous to reference clock.
// R09 - DCE derives MII clocks; DTE ignores reference. In RMII mode the code gates LAN bytes on its rise in DTE too.
// R10 - Reference clock stable before reset release.
// R11 - Reference output divides the system clock.
// R12 - LAN frames to receive queue; serial to transmit.
// R13 - DCE transmit clock 25MHz or 2.5MHz.
package ispl_pkg;

  // ****************************************
  // Clock and frame figures
  // ****************************************
  localparam int SYS_CLK_MHZ     = 125;
  localparam int FRAME_PERIOD_US = 125;
  localparam int T1_CHANNELS     = 24;
  localparam int BYTE_BITS       = 8;
  localparam int FRAMING_BITS    = 1;
  localparam int FRAME_BITS      = FRAMING_BITS + T1_CHANNELS * BYTE_BITS;
  localparam int FRAME_CYCLES    = FRAME_PERIOD_US * SYS_CLK_MHZ;

  // Clock figures: the three frequencies in tenths of a megahertz, then dividers and half periods.
  localparam int REF_MHZ_X10    = 500;
  localparam int MII100_MHZ_X10 = 250;
  localparam int MII10_MHZ_X10  = 25;
  localparam int MII100_HALF    = REF_MHZ_X10 / MII100_MHZ_X10 / 2;
  localparam int MII10_HALF     = REF_MHZ_X10 / MII10_MHZ_X10 / 2;
  localparam int LAN_OUT_DIV    = 4;
  localparam int LINE_HALF      = 8;

  // ****************************************
  // Field positions and fill values
  // ****************************************
  localparam int                 BIT_MSB    = BYTE_BITS - 1;
  localparam logic [2:0]         BIT_LAST   = 3'h7;
  localparam logic [2:0]         BIT_FIRST  = 3'h0;
  localparam logic [2:0]         BIT_SECOND = 3'h1;
  localparam logic [BIT_MSB:0]   IDLE_FILL  = 8'h7e;
  localparam logic [7:0]         SLOT_FRAMING = 8'h00;
  localparam logic [7:0]         SLOT_CH1     = 8'h01;
  localparam logic [7:0]         SLOT_LAST    = 8'(FRAME_BITS - 1);

  // Synchroniser lane positions.
  localparam int SYN_TXCLK = 5;
  localparam int SYN_TXPLS = 4;
  localparam int SYN_RXCLK = 3;
  localparam int SYN_RXSER = 2;
  localparam int SYN_RXPLS = 1;
  localparam int SYN_REF   = 0;
  localparam int SYN_LANES = 6;

endpackage

// file: design/ispl_link_if.sv
// Purpose: Serial link between the mapper end and the framer end.
// Assumes: Both ends run on the same system clock; line clocks are data here.
// Notes:   The framer end makes both line clocks and both frame pulses.
`timescale 1ns/1ps
`default_nettype none
interface ispl_link_if;
  logic txLineClock;
  logic txLineSerial;
  logic txFramePulse;
  logic rxLineClock;
  logic rxLineSerial;
  logic rxFramePulse;

  modport device (
    input  txLineClock,
    output txLineSerial,
    input  txFramePulse,
    input  rxLineClock,
    input  rxLineSerial,
    input  rxFramePulse
  );

  modport framer (
    output txLineClock,
    input  txLineSerial,
    output txFramePulse,
    output rxLineClock,
    output rxLineSerial,
    output rxFramePulse
  );
endinterface
`default_nettype wire

// file: design/ispl_device_end.sv
// Purpose: Mapper end of the serial port, its queues and the LAN clock logic.
// Assumes: Line clocks stay well below a quarter of sys_clk so edges can be sampled.
// Notes:   The 52 MHz ceiling of the pins is not reachable with edge sampling at 125 MHz.
`timescale 1ns/1ps
`default_nettype none

module ispl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // Drain side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;

  wire doWrite = inValid & inReady;
  wire doRead  = outValid & outReady;
  assign inReady  = (count < (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];

  wire [AW-1:0] next_wrPtr = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
  wire [AW-1:0] next_rdPtr = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;

  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= next_wrPtr;
      end
      if (doRead) begin
        rdPtr <= next_rdPtr;
      end
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule

module ispl_device_end
  import ispl_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int LAN_DIV    = ispl_pkg::LAN_OUT_DIV
) (
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  // Serial link
  ispl_link_if.device                      link,
  // Mode straps
  input  wire logic                        x86Mode,
  input  wire logic                        dceMode,
  input  wire logic                        rmiiMode,
  input  wire logic                        speed100,
  // Bytes to send on the serial link
  input  wire logic [ispl_pkg::BIT_MSB:0]  txData,
  input  wire logic                        txValid,
  output logic                             txReady,
  output logic                             txFrameStart,
  // Transmit queue toward the MAC
  output logic      [ispl_pkg::BIT_MSB:0]  txQueueData,
  output logic                             txQueueValid,
  input  wire logic                        txQueueReady,
  output logic                             rxOverflow,
  output logic                             rxFrameStart,
  // LAN side bytes and receive queue
  input  wire logic                        refClockIn,
  input  wire logic [ispl_pkg::BIT_MSB:0]  lanRxData,
  input  wire logic                        lanRxValid,
  output logic                             lanRxReady,
  output logic      [ispl_pkg::BIT_MSB:0]  lanQueueData,
  output logic                             lanQueueValid,
  input  wire logic                        lanQueueReady,
  // LAN clocks
  output logic                             miiClockOut,
  output logic                             miiClockOe,
  output logic                             lanClockOut
);
  import ispl_pkg::*;

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire [SYN_LANES-1:0] rawIn = {link.txLineClock, link.txFramePulse, link.rxLineClock,
                                link.rxLineSerial, link.rxFramePulse, refClockIn};
  logic [SYN_LANES-1:0] meta;
  logic [SYN_LANES-1:0] stable;
  logic [SYN_LANES-1:0] stablePrev;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta       <= '0;
      stable     <= '0;
      stablePrev <= '0;
    end else begin
      meta       <= rawIn;
      stable     <= meta;
      stablePrev <= stable;
    end
  end

  // A gapped clock simply yields no rise, so no bit moves in that period.
  wire txClkRise = stable[SYN_TXCLK] & ~stablePrev[SYN_TXCLK]; // R02
  wire rxClkRise = stable[SYN_RXCLK] & ~stablePrev[SYN_RXCLK]; // R06
  wire refRise   = stable[SYN_REF] & ~stablePrev[SYN_REF];
  wire txPulse   = stable[SYN_TXPLS];
  wire rxPulse   = stable[SYN_RXPLS];
  wire rxBit     = stable[SYN_RXSER];

  // ****************************************
  // Transmit serial path
  // ****************************************
  logic [BIT_MSB:0] txShift;
  logic [2:0]       txBitIdx;
  logic             txSerial;

  wire              txAlign    = txPulse & x86Mode; // R03
  wire              txLoad     = txAlign | (txBitIdx == BIT_LAST);
  wire [BIT_MSB:0]  txNextByte = txValid ? txData : IDLE_FILL;
  assign txReady      = txClkRise & txLoad;
  assign txFrameStart = txClkRise & txPulse; // R03
  assign link.txLineSerial = txSerial;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      txShift  <= IDLE_FILL;
      txBitIdx <= BIT_LAST;
      txSerial <= 1'b0;
    end else if (txClkRise) begin // R01
      if (txLoad) begin
        txSerial <= txNextByte[BIT_MSB];
        txShift  <= {txNextByte[BIT_MSB-1:0], 1'b0};
        txBitIdx <= BIT_FIRST;
      end else begin
        txSerial <= txShift[BIT_MSB];
        txShift  <= {txShift[BIT_MSB-1:0], 1'b0};
        txBitIdx <= txBitIdx + 1'b1;
      end
    end
  end

  // ****************************************
  // Receive serial path
  // ****************************************
  logic [BIT_MSB:0] rxShift;
  logic [2:0]       rxBitIdx;
  logic [BIT_MSB:0] rxByte;
  logic             rxByteValid;
  logic             rxQueueReady;

  wire rxAlign = rxPulse & x86Mode; // R04
  wire rxDone  = rxClkRise & ~rxAlign & (rxBitIdx == BIT_LAST);
  assign rxFrameStart = rxClkRise & rxPulse; // R04

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rxShift     <= '0;
      rxBitIdx    <= BIT_FIRST;
      rxByte      <= '0;
      rxByteValid <= 1'b0;
    end else begin
      rxByteValid <= rxDone;
      if (rxClkRise) begin // R05
        rxShift <= {rxShift[BIT_MSB-1:0], rxBit};
        if (rxAlign) begin
          rxBitIdx <= BIT_SECOND;
        end else begin
          rxBitIdx <= rxBitIdx + 1'b1;
        end
      end
      if (rxDone) begin
        rxByte <= {rxShift[BIT_MSB-1:0], rxBit};
      end
    end
  end

  // The line cannot be stalled, so a byte meeting a full queue is dropped and flagged.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rxOverflow <= 1'b0;
    end else if (rxByteValid & ~rxQueueReady) begin
      rxOverflow <= 1'b1;
    end
  end

  // Serial bytes fill the transmit queue toward the MAC.
  ispl_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) txQueue ( // R12
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .inData   (rxByte),
    .inValid  (rxByteValid),
    .inReady  (rxQueueReady),
    .outData  (txQueueData),
    .outValid (txQueueValid),
    .outReady (txQueueReady)
  );

  // ****************************************
  // LAN receive queue
  // ****************************************
  // In RMII mode a LAN byte is only taken on a reference clock rise.
  wire lanTake = lanRxValid & (~rmiiMode | refRise); // R08
  wire lanFifoReady;
  assign lanRxReady = lanFifoReady & (~rmiiMode | refRise); // R08

  ispl_fifo #(.WIDTH(BYTE_BITS), .DEPTH(FIFO_DEPTH)) lanQueue ( // R12
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .inData   (lanRxData),
    .inValid  (lanTake),
    .inReady  (lanFifoReady),
    .outData  (lanQueueData),
    .outValid (lanQueueValid),
    .outReady (lanQueueReady)
  );

  // ****************************************
  // LAN clocks
  // ****************************************
  localparam int MII_CW = $clog2(MII10_HALF + 1);
  logic [MII_CW-1:0] miiCount;
  logic              miiClock;

  // The reference input counts only in DCE MII mode; in DTE it only gates LAN bytes in RMII mode.
  wire               miiActive = dceMode & ~rmiiMode; // R09
  wire [MII_CW-1:0]  miiHalf   = speed100 ? MII_CW'(MII100_HALF) : MII_CW'(MII10_HALF); // R13
  assign miiClockOut = miiClock;
  assign miiClockOe  = miiActive; // R09

  // Counting assumes the reference was already running at reset release.
  always_ff @(posedge sys_clk) begin
    if (sys_rst | ~miiActive) begin // R10
      miiCount <= '0;
      miiClock <= 1'b0;
    end else if (refRise) begin // R09
      if (miiCount == miiHalf - 1'b1) begin
        miiCount <= '0;
        miiClock <= ~miiClock; // R13
      end else begin
        miiCount <= miiCount + 1'b1;
      end
    end
  end

  localparam int LAN_CW = $clog2(LAN_DIV);
  logic [LAN_CW-1:0] lanCount;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lanCount    <= '0;
      lanClockOut <= 1'b0;
    end else if (lanCount == LAN_CW'(LAN_DIV / 2 - 1)) begin // R11
      lanCount    <= '0;
      lanClockOut <= ~lanClockOut;
    end else begin
      lanCount <= lanCount + 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: design/ispl_framer_end.sv
// Purpose: Framer end that makes the line clocks and frame pulses of a T1 frame.
// Assumes: Same sys_clk as the mapper end.
// Notes:   The framing bit period is gapped, so the mapper sees channel bits only.
`timescale 1ns/1ps
`default_nettype none
module ispl_framer_end
  import ispl_pkg::*;
#(
  parameter int HALF_CYCLES = ispl_pkg::LINE_HALF
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  // Serial link
  ispl_link_if.framer                     link,
  // Line control
  input  wire logic                       linePause,
  input  wire logic                       framingBit,
  // Bytes to send toward the mapper
  input  wire logic [ispl_pkg::BIT_MSB:0] sendData,
  input  wire logic                       sendValid,
  output logic                            sendReady,
  // Bytes taken from the mapper
  output logic      [ispl_pkg::BIT_MSB:0] takeData,
  output logic                            takeValid
);
  import ispl_pkg::*;

  // ****************************************
  // Bit period timing
  // ****************************************
  localparam int PW = $clog2(2 * HALF_CYCLES);
  logic [PW-1:0]    phase;
  logic [7:0]       slot;
  logic             lineClock;
  logic             pulse;
  logic             serialOut;
  logic [BIT_MSB:0] sendShift;
  logic [BIT_MSB:0] takeShift;
  logic [2:0]       takeIdx;

  wire             run       = ~linePause;
  wire             atRise    = run & (phase == '0);
  wire             atFall    = run & (phase == PW'(HALF_CYCLES));
  wire             lastPhase = (phase == PW'(2 * HALF_CYCLES - 1));
  wire [7:0]       nextSlot  = (slot == SLOT_LAST) ? SLOT_FRAMING : slot + 1'b1;
  wire             gapped    = (slot == SLOT_FRAMING); // R07
  wire [2:0]       nextBit   = 3'(nextSlot - SLOT_CH1);
  wire             loadByte  = atFall & (nextSlot != SLOT_FRAMING) & (nextBit == BIT_FIRST);
  wire [BIT_MSB:0] loadValue = sendValid ? sendData : IDLE_FILL;
  assign sendReady = loadByte;

  assign link.txLineClock  = lineClock;
  assign link.rxLineClock  = lineClock;
  assign link.txFramePulse = pulse;
  assign link.rxFramePulse = pulse;
  assign link.rxLineSerial = serialOut;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase     <= '0;
      slot      <= SLOT_FRAMING;
      lineClock <= 1'b0;
    end else if (run) begin
      phase <= lastPhase ? '0 : phase + 1'b1;
      if (lastPhase) begin
        slot <= nextSlot;
      end
      if (atRise) begin
        lineClock <= ~gapped; // R07
      end else if (atFall) begin
        lineClock <= 1'b0;
      end
    end
  end

  // ****************************************
  // Data toward the mapper
  // ****************************************
  // Data and pulse change half a period before the rise that takes them.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pulse     <= 1'b0;
      serialOut <= 1'b0;
      sendShift <= IDLE_FILL;
    end else if (atFall) begin
      pulse <= (nextSlot == SLOT_CH1); // R04
      if (nextSlot == SLOT_FRAMING) begin
        serialOut <= framingBit; // R07
      end else if (loadByte) begin
        serialOut <= loadValue[BIT_MSB];
        sendShift <= {loadValue[BIT_MSB-1:0], 1'b0};
      end else begin
        serialOut <= sendShift[BIT_MSB];
        sendShift <= {sendShift[BIT_MSB-1:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Data from the mapper
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      takeShift <= '0;
      takeIdx   <= BIT_FIRST;
      takeData  <= '0;
      takeValid <= 1'b0;
    end else begin
      takeValid <= 1'b0;
      if (atFall & ~gapped) begin
        takeShift <= {takeShift[BIT_MSB-1:0], link.txLineSerial};
        takeIdx   <= (slot == SLOT_CH1) ? BIT_SECOND : takeIdx + 1'b1;
        if ((slot != SLOT_CH1) && (takeIdx == BIT_LAST)) begin
          takeData  <= {takeShift[BIT_MSB-1:0], link.txLineSerial};
          takeValid <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/ispl_link_sva.sv
// Purpose: Concurrent checks on the serial link between the mapper end and the framer end.
// Assumes: One sys_clk domain, framer half period of 8 cycles, line never paused.
// Notes:   Frame checks count clock rises, so the gapped framing slot is seen as a long low.
`timescale 1ns/1ps
`default_nettype none
module ispl_link_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Link signals
  input wire logic txLineClock,
  input wire logic txLineSerial,
  input wire logic txFramePulse,
  input wire logic rxLineClock,
  input wire logic rxLineSerial,
  input wire logic rxFramePulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // Helper counters
  // ****************************************
  logic       prevClk;
  logic       prevPls;
  logic       clkRise;
  logic       plsRise;
  logic       seenPulse;
  logic [7:0] riseCount;
  logic [4:0] lowCount;
  assign clkRise = txLineClock & ~prevClk;
  assign plsRise = txFramePulse & ~prevPls;

  always_ff @(posedge sys_clk) begin
    prevClk <= txLineClock;
    prevPls <= txFramePulse;
  end

  // The first frame after reset may be partial, so it is never judged.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seenPulse <= 1'b0;
      riseCount <= 8'h00;
    end else if (plsRise) begin
      seenPulse <= 1'b1;
      riseCount <= 8'h00;
    end else if (clkRise) begin
      riseCount <= riseCount + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || txLineClock) begin
      lowCount <= 5'h00;
    end else if (lowCount != 5'h1f) begin
      lowCount <= lowCount + 5'h01;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  property p_tx_launch;
    $changed(txLineSerial) && !$past(sys_rst) |-> $past(clkRise, 3) || $past(clkRise, 4) || $past(clkRise, 5);
  endproperty
  property p_tx_gap_hold;
    !txLineClock [*8] |=> $stable(txLineSerial);
  endproperty
  property p_pulse_lead;
    $rose(txFramePulse) |-> !txLineClock ##[1:12] $rose(txLineClock);
  endproperty
  property p_pulse_pair;
    txFramePulse == rxFramePulse;
  endproperty
  property p_rx_change_low;
    $changed(rxLineSerial) && !$past(sys_rst) |-> !rxLineClock;
  endproperty
  property p_clk_pair;
    txLineClock == rxLineClock;
  endproperty
  property p_clk_high;
    $rose(txLineClock) |-> txLineClock [*8] ##1 !txLineClock;
  endproperty
  property p_frame_rises;
    plsRise && seenPulse |-> riseCount == 8'hc0;
  endproperty
  property p_framing_gap;
    plsRise && seenPulse |-> lowCount >= 5'h0c;
  endproperty

  a_tx_launch: assert property (p_tx_launch) else $error("Transmit bit moved without a clock rise");
  a_tx_gap_hold: assert property (p_tx_gap_hold) else $error("Transmit bit moved in a gap");
  a_pulse_lead: assert property (p_pulse_lead) else $error("Frame pulse not ahead of a rise");
  a_pulse_pair: assert property (p_pulse_pair) else $error("Frame pulses differ");
  a_rx_change_low: assert property (p_rx_change_low) else $error("Receive bit moved with clock high");
  a_clk_pair: assert property (p_clk_pair) else $error("Line clocks differ");
  a_clk_high: assert property (p_clk_high) else $error("Line clock high time wrong");
  a_frame_rises: assert property (p_frame_rises) else $error("Frame does not hold 192 channel bits");
  a_framing_gap: assert property (p_framing_gap) else $error("No framing slot before channel 1");

  c_frame: cover property (plsRise && seenPulse);
  c_tx_bit: cover property ($changed(txLineSerial));
  c_rx_bit: cover property ($changed(rxLineSerial));
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Purpose: Runs bytes both ways over the link, fills the queues and measures the LAN clocks.
// Assumes: Framer half period 8, FIFO depth 8, byte alignment from the frame pulse.
// Notes:   Idle fill bytes are dropped from what is collected, since they arrive all the time.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ispl_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       refClockIn = 1'b0;
  logic       dceMode = 1'b1;
  logic       rmiiMode = 1'b0;
  logic       speed100 = 1'b1;
  logic [7:0] txData = 8'h00;
  logic       txValid = 1'b0;
  logic       txQueueReady = 1'b1;
  logic [7:0] lanRxData = 8'h00;
  logic       lanRxValid = 1'b0;
  logic       lanQueueReady = 1'b0;
  logic [7:0] sendData = 8'h00;
  logic       sendValid = 1'b0;
  logic [7:0] txQueueData, lanQueueData, takeData;
  logic       txReady, txFrameStart, txQueueValid, rxOverflow, rxFrameStart, lanRxReady;
  logic       lanQueueValid, miiClockOut, miiClockOe, lanClockOut, sendReady, takeValid;
  logic [7:0] rxSeen[$];
  logic [7:0] txSeen[$];
  int         badCount = 0;
  int         testsRun = 0;
  int         i;
  int         n;
  int         m;
  int         r;
  int         l;

  always #4 sys_clk = ~sys_clk;
  always #10 refClockIn = ~refClockIn;

  ispl_link_if linkBus ();
  ispl_device_end #(.FIFO_DEPTH(8), .LAN_DIV(LAN_OUT_DIV)) ispl_device_end_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(linkBus), .x86Mode(1'b1), .dceMode(dceMode),
    .rmiiMode(rmiiMode), .speed100(speed100), .txData(txData), .txValid(txValid), .txReady(txReady),
    .txFrameStart(txFrameStart), .txQueueData(txQueueData), .txQueueValid(txQueueValid),
    .txQueueReady(txQueueReady), .rxOverflow(rxOverflow), .rxFrameStart(rxFrameStart),
    .refClockIn(refClockIn), .lanRxData(lanRxData), .lanRxValid(lanRxValid), .lanRxReady(lanRxReady),
    .lanQueueData(lanQueueData), .lanQueueValid(lanQueueValid), .lanQueueReady(lanQueueReady),
    .miiClockOut(miiClockOut), .miiClockOe(miiClockOe), .lanClockOut(lanClockOut));
  ispl_framer_end #(.HALF_CYCLES(LINE_HALF)) ispl_framer_end_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .link(linkBus), .linePause(1'b0), .framingBit(1'b0),
    .sendData(sendData), .sendValid(sendValid), .sendReady(sendReady), .takeData(takeData),
    .takeValid(takeValid));
  ispl_link_sva ispl_link_sva_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .txLineClock(linkBus.txLineClock),
    .txLineSerial(linkBus.txLineSerial), .txFramePulse(linkBus.txFramePulse),
    .rxLineClock(linkBus.rxLineClock), .rxLineSerial(linkBus.rxLineSerial),
    .rxFramePulse(linkBus.rxFramePulse));

  always @(posedge sys_clk) begin
    if (txQueueValid === 1'b1 && txQueueReady === 1'b1 && txQueueData !== IDLE_FILL) rxSeen.push_back(txQueueData);
    if (takeValid === 1'b1 && takeData !== IDLE_FILL) txSeen.push_back(takeData);
  end

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [7:0] pat(input int k);
    return 8'(k * 37 + 1);
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    testsRun++;
    if (seen !== expected) begin
      badCount++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expected);
    end
  endtask

  task automatic final_report();
    $display("Compares %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic giveUp(input int k, input int bound);
    if (k >= bound) begin
      check(8'h00, 8'h01);
      final_report();
    end
  endtask

  task automatic waitCycles(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Data and valid stay put until the edge that samples the ready pulse.
  task automatic frameSend(input logic [7:0] value);
    int k;
    sendData = value;
    sendValid = 1'b1;
    for (k = 0; k < 400; k++) begin
      @(posedge sys_clk);
      if (sendReady === 1'b1) break;
    end
    giveUp(k, 400);
    #1;
  endtask

  task automatic deviceSend(input logic [7:0] value);
    int k;
    txData = value;
    txValid = 1'b1;
    for (k = 0; k < 400; k++) begin
      @(posedge sys_clk);
      if (txReady === 1'b1) break;
    end
    giveUp(k, 400);
    #1;
  endtask

  task automatic compareSeq(input logic [7:0] got[$], input int count);
    check(8'(got.size()), 8'(count));
    for (int j = 0; j < count && j < got.size(); j++) check(got[j], pat(j));
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    for (i = 0; i < 4000 && rxFrameStart !== 1'b1; i++) @(posedge sys_clk);
    giveUp(i, 4000);
    check({7'h00, txFrameStart}, 8'h01);
    waitCycles(300);
    rxSeen.delete();
    for (i = 0; i < 30; i++) frameSend(pat(i));
    sendValid = 1'b0;
    waitCycles(500);
    compareSeq(rxSeen, 30);
    check({7'h00, rxOverflow}, 8'h00);
    $display("Test receive path done");
    txSeen.delete();
    for (i = 0; i < 30; i++) deviceSend(pat(i));
    txValid = 1'b0;
    waitCycles(600);
    compareSeq(txSeen, 30);
    $display("Test transmit path done");
    txQueueReady = 1'b0;
    rxSeen.delete();
    for (i = 0; i < 10; i++) frameSend(pat(i));
    sendValid = 1'b0;
    waitCycles(300);
    check({7'h00, rxOverflow}, 8'h01);
    txQueueReady = 1'b1;
    waitCycles(20);
    check(8'(rxSeen.size() >= 6), 8'h01);
    for (i = 0; i < rxSeen.size(); i++) check(rxSeen[i], pat(i));
    $display("Test queue overflow done");
    n = 0;
    lanRxValid = 1'b1;
    for (i = 0; i < 12; i++) begin
      lanRxData = 8'hc0 + 8'(n);
      @(posedge sys_clk);
      if (lanRxReady === 1'b1) n++;
      #1;
    end
    lanRxValid = 1'b0;
    check(8'(n), 8'h08);
    lanQueueReady = 1'b1;
    for (i = 0; i < 8; i++) begin
      check(lanQueueData, 8'hc0 + 8'(i));
      waitCycles(1);
    end
    check({7'h00, lanQueueValid}, 8'h00);
    rmiiMode = 1'b1;
    lanRxValid = 1'b1;
    n = 0;
    r = 0;
    for (i = 0; i < 100; i++) begin
      l = int'(refClockIn);
      @(posedge sys_clk);
      n += int'(lanRxReady === 1'b1);
      #1;
      r += int'(refClockIn === 1'b1 && l == 0);
    end
    lanRxValid = 1'b0;
    rmiiMode = 1'b0;
    check(8'(n >= r - 2 && n <= r + 2), 8'h01);
    $display("Test LAN queue done");
    for (int s = 1; s >= 0; s--) begin
      speed100 = s[0];
      waitCycles(50);
      m = 0;
      r = 0;
      l = 0;
      for (i = 0; i < 500; i++) begin
        logic pm, pr, pl;
        pm = miiClockOut;
        pr = refClockIn;
        pl = lanClockOut;
        @(posedge sys_clk);
        #1;
        m += int'(miiClockOut !== pm);
        r += int'(refClockIn === 1'b1 && pr === 1'b0);
        l += int'(lanClockOut !== pl);
      end
      n = (s == 1) ? r : r / 10;
      check(8'(m >= n - 2 && m <= n + 2), 8'h01);
      check(8'(l >= 1000 / LAN_OUT_DIV - 1 && l <= 1000 / LAN_OUT_DIV + 1), 8'h01);
    end
    for (i = 0; i < 4; i++) begin
      dceMode = i[1];
      rmiiMode = i[0];
      #1;
      check({7'h00, miiClockOe}, {7'h00, i[1] & ~i[0]});
    end
    $display("Test LAN clocks done");
    final_report();
  end
endmodule
`default_nettype wire
